// ===== asp_regs.vh
// Overview of operation
// [RULE_01] pin register 31:8 holds destination, resets zero
// [RULE_02] pin bit 0 enables pin; 7:1 reserved
// [RULE_03] dropped flag bit 24, cleared by read
// [RULE_04] width code 17:16, left aligned, reset 1
// [RULE_05] code 1: 16 bits, MSB first
// [RULE_06] code 3: 32 bits, MSB first
// [RULE_07] bits 15:8 set samples per packet
// [RULE_08] zero count: end packet on register access; code ends it only on pin or general control access
// [RULE_09] bit 1 selects internal calibration reference
// [RULE_10] consumer discards one sample on cal change
// [RULE_11] bit 0 enables converter, resets zero
// [RULE_12] pin registers read-only while converter enabled
// [RULE_13] software configures pins with converter disabled
// [RULE_14] six calibration pulses after enable, no packets
// [RULE_15] seventh pulse onward delivers samples
// [RULE_16] flag drop when sample not forwarded in time
`ifndef ASP_REGS_VH
`define ASP_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define ASP_OFF_PIN7 8'h1c
`define ASP_OFF_GCTL 8'h20
`define ASP_OFF_STAT 8'h24
`define ASP_OFF_MASK 8'h28

// ****************************************
// field positions
// ****************************************
`define ASP_PIN_EN_BIT 0
`define ASP_PIN_DEST_LSB 8
`define ASP_GC_EN_BIT 0
`define ASP_GC_CAL_BIT 1
`define ASP_GC_SPP_LSB 8
`define ASP_GC_WID_LSB 16
`define ASP_GC_DROP_BIT 24
`define ASP_ST_DROP_BIT 0
`define ASP_ST_PKT_BIT 1
`define ASP_ST_CAL_BIT 2

// ****************************************
// reset values and codes
// ****************************************
`define ASP_DEST_RST 24'h000000
`define ASP_SPP_RST 8'h01
`define ASP_WID_RST 2'h1
`define ASP_DROP_RST 1'b1
`define ASP_WID_8 2'h0
`define ASP_WID_16 2'h1
`define ASP_WID_32 2'h3
`define ASP_CAL_PULSES 3'h6
`define ASP_NUM_PINS 8

`endif

// ===== asp_slot.v
`include "asp_regs.vh"

// one sample holding slot and packet bookkeeping for a single pin
module asp_slot (
  input wire clock,
  input wire rstn,
  input wire load,
  input wire [11:0] din,
  input wire take,
  input wire end_done,
  input wire close_req,
  output reg pending,
  output reg [11:0] data,
  output reg open,
  output reg close,
  output reg [7:0] cnt,
  output wire drop
);

  // ****************************************
  // overrun detect
  // ****************************************
  // [RULE_16] overrun flags drop
  assign drop = load & pending & ~take;

  // ****************************************
  // slot state
  // ****************************************
  // pending set wins over take, open tracks packet
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pending <= 1'b0;
      data <= 12'h000;
      open <= 1'b0;
      close <= 1'b0;
      cnt <= 8'h00;
    end else begin
      // new sample overwrites any unsent one
      if (load) begin
        data <= din;
      end
      pending <= load | (pending & ~take);
      // sample leaves: packet open, count it
      if (take) begin
        open <= 1'b1;
        cnt <= cnt + 8'h01;
      end else if (end_done) begin
        open <= 1'b0;
        cnt <= 8'h00;
      end
      // close request only meaningful on an open packet
      close <= (close_req & (open | take)) | (close & ~end_done & open);
    end
  end

endmodule // asp_slot

// ===== asp_ctrl.v
// The APB register port was chosen for this implementation.
`include "asp_regs.vh"

// converter sample packet controller: apb registers, gating, byte stream out
module asp_ctrl (
  input wire clock,
  input wire rstn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  // converter side
  input wire conv_trigger,
  input wire sample_valid,
  input wire [2:0] sample_pin,
  input wire [11:0] sample_data,
  output wire conv_enable,
  output wire conv_cal_ref,
  output wire conv_start,
  // channel end byte stream
  output wire tx_valid,
  output reg [7:0] tx_data,
  output wire tx_end,
  output reg [23:0] tx_dest,
  input wire tx_ready,
  // interrupt
  output wire irq
);

  // ****************************************
  // fsm states
  // ****************************************
  localparam ST_IDLE = 2'h0;
  localparam ST_BYTE = 2'h1;
  localparam ST_END = 2'h2;

  // ****************************************
  // declarations
  // ****************************************
  reg [23:0] dest_r [0:7]; // per pin destination
  reg [7:0] pin_en_r; // per pin enable
  reg en_r; // converter enable
  reg cal_r; // calibration reference select
  reg [7:0] spp_r; // samples per packet
  reg [1:0] wid_r; // sample width code
  reg drop_r; // dropped sample flag
  reg [2:0] stat_r; // sticky events
  reg [2:0] mask_r; // interrupt mask
  reg [2:0] cal_cnt_r; // calibration pulses seen
  reg [1:0] state_r; // serializer state
  reg [2:0] sel_r; // pin being served
  reg [31:0] shift_r; // outgoing word
  reg [1:0] left_r; // bytes left minus one
  reg [1:0] state_nxt;
  reg [7:0] take_v; // slot consumed this cycle
  reg [7:0] end_v; // packet end sent this cycle
  reg [2:0] pick_idx; // chosen pin
  reg pick_close; // chosen for close
  reg pick_any; // something to serve
  reg [31:0] fmt_word; // formatted sample
  reg [1:0] fmt_left; // its byte count minus one
  reg [31:0] rd_mux; // read data mux
  reg rd_ok; // address mapped
  integer i; // loop index, combinational pick only
  integer j; // loop index, register reset only
  wire [7:0] pend_w;
  wire [7:0] open_w;
  wire [7:0] close_w;
  wire [7:0] drop_w;
  wire [7:0] cnt_w [0:7];
  wire [11:0] data_w [0:7];
  wire [7:0] load_w;
  wire [7:0] close_req_w;
  wire setup;
  wire access;
  wire wr;
  wire rd;
  wire pin_hit;
  wire ctl_hit;
  wire any_drop;
  wire cal_done;
  wire pkt_done;
  wire [2:0] ev;

  // ****************************************
  // apb decode
  // ****************************************
  // zero wait states, error on unmapped
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign wr = access & pwrite & rd_ok;
  assign rd = access & ~pwrite & rd_ok;
  assign pslverr = access & ~rd_ok;
  assign pin_hit = (paddr <= `ASP_OFF_PIN7) & (paddr[1:0] == 2'h0);
  assign ctl_hit = pin_hit | (paddr == `ASP_OFF_GCTL);

  // read mux and address check
  always @* begin
    rd_mux = 32'h00000000;
    rd_ok = 1'b1;
    if (pin_hit) begin
      // [RULE_02] reserved bits zero
      rd_mux = {dest_r[paddr[4:2]], 7'h00, pin_en_r[paddr[4:2]]};
    end else if (paddr == `ASP_OFF_GCTL) begin
      rd_mux = {7'h00, drop_r, 6'h00, wid_r, spp_r, 6'h00, cal_r, en_r};
    end else if (paddr == `ASP_OFF_STAT) begin
      rd_mux = {29'h0, stat_r};
    end else if (paddr == `ASP_OFF_MASK) begin
      rd_mux = {29'h0, mask_r};
    end else begin
      rd_ok = 1'b0;
    end
  end

  // read data captured in setup so it is a flop at access
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h00000000;
    end else if (setup) begin
      prdata <= rd_mux;
    end
  end

  // ****************************************
  // register writes
  // ****************************************
  // per pin and general control storage
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      for (j = 0; j < `ASP_NUM_PINS; j = j + 1) begin
        dest_r[j] <= `ASP_DEST_RST;
      end
      pin_en_r <= 8'h00;
      en_r <= 1'b0;
      cal_r <= 1'b0;
      spp_r <= `ASP_SPP_RST;
      wid_r <= `ASP_WID_RST;
      mask_r <= 3'h0;
    end else if (wr) begin
      // [RULE_12] locked while enabled
      if (pin_hit & ~en_r) begin
        // [RULE_01] destination field
        dest_r[paddr[4:2]] <= pwdata[31:`ASP_PIN_DEST_LSB];
        // [RULE_02] pin enable bit
        pin_en_r[paddr[4:2]] <= pwdata[`ASP_PIN_EN_BIT];
      end
      if (paddr == `ASP_OFF_GCTL) begin
        // [RULE_11] converter enable
        en_r <= pwdata[`ASP_GC_EN_BIT];
        // [RULE_09] calibration reference
        cal_r <= pwdata[`ASP_GC_CAL_BIT];
        // [RULE_07] packet length
        spp_r <= pwdata[`ASP_GC_SPP_LSB+7:`ASP_GC_SPP_LSB];
        // [RULE_04] width code
        wid_r <= pwdata[`ASP_GC_WID_LSB+1:`ASP_GC_WID_LSB];
      end
      if (paddr == `ASP_OFF_MASK) begin
        mask_r <= pwdata[2:0];
      end
    end
  end

  // ****************************************
  // converter control
  // ****************************************
  assign conv_enable = en_r;
  assign conv_cal_ref = cal_r;
  assign conv_start = conv_trigger & en_r;
  assign cal_done = conv_start & (cal_cnt_r == `ASP_CAL_PULSES - 3'h1);

  // counts startup pulses after each rising enable
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cal_cnt_r <= 3'h0;
    end else begin
      // [RULE_14] zero while off, so 0 to 1 restarts
      // a stale full count would pass a sample in the first enabled cycle
      if (~en_r) begin
        cal_cnt_r <= 3'h0;
      end else if (conv_start & (cal_cnt_r != `ASP_CAL_PULSES)) begin
        cal_cnt_r <= cal_cnt_r + 3'h1;
      end
    end
  end

  // ****************************************
  // sample slots
  // ****************************************
  // [RULE_15] deliver after six pulses
  assign load_w = (sample_valid & en_r & (cal_cnt_r == `ASP_CAL_PULSES)) ?
                  (pin_en_r & (8'h01 << sample_pin)) : 8'h00;
  // [RULE_08] pin or general control access ends endless packets
  assign close_req_w = (access & ctl_hit & (spp_r == 8'h00)) ? 8'hff : 8'h00;

  genvar g;
  generate
    for (g = 0; g < `ASP_NUM_PINS; g = g + 1) begin : g_slot
      asp_slot u_slot (
        .clock(clock),
        .rstn(rstn),
        .load(load_w[g]),
        .din(sample_data),
        .take(take_v[g]),
        .end_done(end_v[g]),
        .close_req(close_req_w[g]),
        .pending(pend_w[g]),
        .data(data_w[g]),
        .open(open_w[g]),
        .close(close_w[g]),
        .cnt(cnt_w[g]),
        .drop(drop_w[g])
      );
    end
  endgenerate

  // ****************************************
  // pick and format
  // ****************************************
  // lowest pin first, closes before samples
  always @* begin
    pick_idx = 3'h0;
    pick_close = 1'b0;
    pick_any = 1'b0;
    for (i = `ASP_NUM_PINS - 1; i >= 0; i = i - 1) begin
      if (pend_w[i]) begin
        pick_idx = i[2:0];
        pick_any = 1'b1;
      end
    end
    for (i = `ASP_NUM_PINS - 1; i >= 0; i = i - 1) begin
      if (close_w[i] & open_w[i]) begin
        pick_idx = i[2:0];
        pick_close = 1'b1;
        pick_any = 1'b1;
      end
    end
  end

  // left aligned sample, msb byte first
  always @* begin
    case (wid_r)
      // [RULE_04] drop low four bits
      `ASP_WID_8: begin
        fmt_word = {data_w[pick_idx][11:4], 24'h000000};
        fmt_left = 2'h0;
      end
      // [RULE_06] pad twenty zeros
      `ASP_WID_32: begin
        fmt_word = {data_w[pick_idx], 20'h00000};
        fmt_left = 2'h3;
      end
      // [RULE_05] pad four zeros
      default: begin
        fmt_word = {data_w[pick_idx], 4'h0, 16'h0000};
        fmt_left = 2'h1;
      end
    endcase
  end

  // ****************************************
  // serializer
  // ****************************************
  assign tx_valid = (state_r == ST_BYTE) | (state_r == ST_END);
  assign tx_end = (state_r == ST_END);
  assign pkt_done = tx_end & tx_ready;

  // next state and slot strobes
  always @* begin
    state_nxt = state_r;
    take_v = 8'h00;
    end_v = 8'h00;
    case (state_r)
      ST_IDLE: begin
        if (pick_any & pick_close) begin
          state_nxt = ST_END;
        end else if (pick_any) begin
          take_v = 8'h01 << pick_idx;
          state_nxt = ST_BYTE;
        end
      end
      ST_BYTE: begin
        if (tx_ready & (left_r == 2'h0)) begin
          // [RULE_07] end after spp samples
          if ((spp_r != 8'h00) & (cnt_w[sel_r] >= spp_r)) begin
            state_nxt = ST_END;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_END: begin
        if (tx_ready) begin
          end_v = 8'h01 << sel_r;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // shift register and output data flops
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      sel_r <= 3'h0;
      shift_r <= 32'h00000000;
      left_r <= 2'h0;
      tx_data <= 8'h00;
      tx_dest <= 24'h000000;
    end else begin
      state_r <= state_nxt;
      if ((state_r == ST_IDLE) & pick_any) begin
        sel_r <= pick_idx;
        tx_dest <= dest_r[pick_idx];
        if (pick_close) begin
          tx_data <= 8'h00;
        end else begin
          tx_data <= fmt_word[31:24];
          shift_r <= {fmt_word[23:0], 8'h00};
          left_r <= fmt_left;
        end
      end else if ((state_r == ST_BYTE) & tx_ready) begin
        tx_data <= shift_r[31:24];
        shift_r <= {shift_r[23:0], 8'h00};
        left_r <= left_r - 2'h1;
      end
    end
  end

  // ****************************************
  // drop flag and interrupts
  // ****************************************
  assign any_drop = |drop_w;
  assign ev = {cal_done, pkt_done, any_drop};
  assign irq = |(stat_r & mask_r);

  // sticky flags, set wins over clear
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      drop_r <= `ASP_DROP_RST;
      stat_r <= 3'h0;
    end else begin
      // [RULE_16] hold drop indication
      // [RULE_03] read of general control clears
      drop_r <= any_drop | (drop_r & ~(rd & (paddr == `ASP_OFF_GCTL)));
      if (wr & (paddr == `ASP_OFF_STAT)) begin
        stat_r <= ev | (stat_r & ~pwdata[2:0]);
      end else begin
        stat_r <= ev | stat_r;
      end
    end
  end

endmodule // asp_ctrl

// ===== asp_ctrl_asserts.sv
// ****
// port checker for the sample controller
// ****
module asp_ctrl_chk (
  input wire clock,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire conv_trigger,
  input wire conv_enable,
  input wire conv_cal_ref,
  input wire conv_start,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_end,
  input wire [23:0] tx_dest,
  input wire tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // completed write to general control
  wire gc_w = psel && penable && pwrite && paddr == 8'h20;
  wire en_d = pwdata[0];
  wire cal_d = pwdata[1];
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence gc_wr;
    gc_w;
  endsequence
  // beat offered but not taken
  sequence stalled;
    tx_valid && !tx_ready;
  endsequence
  start_gate_a: assert property (conv_start == (conv_trigger && conv_enable))
    else $error("start pulse not gated by enable");
  enable_write_a: assert property (gc_wr |=> conv_enable == $past(en_d))
    else $error("enable does not follow write");
  enable_hold_a: assert property (!gc_w |=> $stable(conv_enable))
    else $error("enable moved without write");
  cal_write_a: assert property (gc_wr |=> conv_cal_ref == $past(cal_d))
    else $error("reference select does not follow write");
  cal_hold_a: assert property (!gc_w |=> $stable(conv_cal_ref))
    else $error("reference select moved without write");
  beat_hold_a: assert property (stalled |=> tx_valid)
    else $error("beat withdrawn before acceptance");
  data_hold_a: assert property (stalled |=> $stable({tx_data, tx_end, tx_dest}))
    else $error("beat changed before acceptance");
  end_zero_a: assert property (tx_valid && tx_end |-> tx_data == 8'h00)
    else $error("end beat carries data");
endmodule // asp_ctrl_chk

bind asp_ctrl asp_ctrl_chk i_asp_ctrl_chk (.clock, .rstn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .conv_trigger, .conv_enable, .conv_cal_ref, .conv_start, .tx_valid, .tx_data,
  .tx_end, .tx_dest, .tx_ready);

// ===== asp_chan_sink.sv
// ****
// channel end consumer model
// ****
module asp_chan_sink (
  input wire clock,
  input wire rstn,
  input wire slow,
  input wire hold,
  input wire tx_valid,
  input wire [7:0] tx_data,
  input wire tx_end,
  input wire [23:0] tx_dest,
  output reg tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // accepted beats: end flag, destination, byte
  logic [63:0] got[$];
  // accept beats; slow halves the rate, hold stalls
  always @(posedge clock or negedge rstn) begin
    if (!rstn)
      tx_ready <= 1'h0;
    else begin
      if (tx_valid && tx_ready)
        got.push_back({31'h0, tx_end, tx_dest, tx_data});
      tx_ready <= !hold && (!slow || !tx_ready);
    end
  end
endmodule // asp_chan_sink

// ===== asp_ctrl_bench.sv
module asp_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic conv_trigger = 1'h0, sample_valid = 1'h0, slow = 1'h0, hold = 1'h0, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd;
  logic [2:0] sample_pin = 3'h7;
  logic [11:0] sample_data = 12'h000;
  wire pready, pslverr, conv_enable, conv_cal_ref, conv_start, tx_valid, tx_end, tx_ready, irq;
  wire [31:0] prdata;
  wire [7:0] tx_data;
  wire [23:0] tx_dest;
  logic [63:0] exq[$];
  int miscompares = 0, n_checks = 0;
  localparam logic [23:0] DST = 24'h5a3c96;
  asp_ctrl i_asp_ctrl (.clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .conv_trigger, .sample_valid, .sample_pin, .sample_data, .conv_enable,
    .conv_cal_ref, .conv_start, .tx_valid, .tx_data, .tx_end, .tx_dest, .tx_ready, .irq);
  asp_chan_sink i_asp_chan_sink (.clock, .rstn, .slow, .hold, .tx_valid, .tx_data, .tx_end,
    .tx_dest, .tx_ready);
  initial forever #4 clock = ~clock;
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, read data and error taken at the ready edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    @(posedge clock);
    for (n = 0; n < 50 && pready !== 1'h1; n++) @(posedge clock);
    if (n == 50) begin
      miscompares++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // trigger pulse or converted sample
  task pulse(input logic t, input logic [11:0] s);
    @(posedge clock);
    conv_trigger <= t;
    sample_valid <= !t;
    sample_data <= s;
    @(posedge clock);
    conv_trigger <= 1'h0;
    sample_valid <= 1'h0;
  endtask
  task push(input logic e, input logic [7:0] b);
    exq.push_back({31'h0, e, DST, b});
  endtask
  // left aligned sample bytes, most significant first
  task exp_s(input logic [11:0] s, input logic [1:0] w);
    push(1'h0, s[11:4]);
    if (w != 2'h0) push(1'h0, {s[3:0], 4'h0});
    if (w == 2'h3) begin
      push(1'h0, 8'h00);
      push(1'h0, 8'h00);
    end
  endtask
  task drain(input string what);
    int n;
    for (n = 0; n < 500 && i_asp_chan_sink.got.size() < exq.size(); n++) @(posedge clock);
    if (n == 500) begin
      miscompares++;
      summarize();
    end
    repeat (6) @(posedge clock);
    chk(what, exq.size(), i_asp_chan_sink.got.size());
    while (exq.size() > 0 && i_asp_chan_sink.got.size() > 0)
      chk(what, exq.pop_front(), i_asp_chan_sink.got.pop_front());
    exq.delete();
    i_asp_chan_sink.got.delete();
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    apb(1'h0, 8'h1c, 32'h0);
    chk("pin7 reset", 32'h0, rd);
    apb(1'h0, 8'h20, 32'h0);
    chk("gctl reset", 32'h01010100, rd);
    apb(1'h0, 8'h20, 32'h0);
    chk("drop read clear", 32'h00010100, rd);
    apb(1'h0, 8'h40, 32'h0);
    chk("unmapped error", 1'h1, er);
    $display("reset test done");
    apb(1'h1, 8'h1c, {DST, 8'hff});
    apb(1'h0, 8'h1c, 32'h0);
    chk("pin7 config", {DST, 8'h01}, rd);
    apb(1'h1, 8'h20, 32'h00010101);
    apb(1'h1, 8'h1c, 32'h0);
    apb(1'h0, 8'h1c, 32'h0);
    chk("pin7 locked", {DST, 8'h01}, rd);
    for (int i = 0; i < 6; i++) begin
      pulse(1'h0, 12'h111);
      pulse(1'h1, 12'h000);
    end
    drain("calibration");
    exp_s(12'habc, 2'h1);
    push(1'h1, 8'h00);
    pulse(1'h0, 12'habc);
    drain("first sample");
    $display("enable test done");
    for (int w = 0; w < 4; w++) begin
      slow <= w[1];
      apb(1'h1, 8'h20, {14'h0, w[1:0], 16'h0201});
      exp_s({10'h276, w[1:0]}, w[1:0]);
      pulse(1'h0, {10'h276, w[1:0]});
      drain("width first");
      exp_s(12'h3c7, w[1:0]);
      push(1'h1, 8'h00);
      pulse(1'h0, 12'h3c7);
      drain("width second");
    end
    slow <= 1'h0;
    $display("width test done");
    apb(1'h1, 8'h20, 32'h00030001);
    exp_s(12'h5e1, 2'h3);
    pulse(1'h0, 12'h5e1);
    drain("open packet");
    push(1'h1, 8'h00);
    apb(1'h0, 8'h1c, 32'h0);
    drain("closed packet");
    $display("open packet test done");
    hold <= 1'h1;
    apb(1'h1, 8'h28, 32'h1);
    repeat (3) pulse(1'h0, 12'h777);
    apb(1'h0, 8'h20, 32'h0);
    chk("drop flag", 32'h01030001, rd);
    chk("irq raised", 1'h1, irq);
    apb(1'h1, 8'h24, 32'h1);
    apb(1'h0, 8'h20, 32'h0);
    chk("drop cleared", 32'h00030001, rd);
    chk("irq cleared", 1'h0, irq);
    hold <= 1'h0;
    repeat (60) @(posedge clock);
    i_asp_chan_sink.got.delete();
    apb(1'h1, 8'h20, 32'h00010002);
    apb(1'h0, 8'h20, 32'h0);
    chk("calibration select", 32'h00010002, rd);
    chk("cal reference pin", 1'h1, conv_cal_ref);
    chk("converter enable pin", 1'h0, conv_enable);
    $display("drop test done");
    summarize();
  end
endmodule // asp_ctrl_bench
